// *** src/sirq_pkg.sv ***
// package of constants for the sensor interrupt status and register read port
package sirq_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] SIRQ_ADDR_FLAGS   = 8'h8E;
   localparam logic [7:0] SIRQ_ADDR_MODTIM  = 8'h8F;
   localparam logic [7:0] SIRQ_ADDR_AMBIR   = 8'h90;
   localparam logic [7:0] SIRQ_MODTIM_RST   = 8'h01;
   localparam logic [7:0] SIRQ_PTR_RST      = 8'h00;
   localparam logic [6:0] SIRQ_SLAVE_ADDR   = 7'h13;
   // ****************************************
   // field positions
   // ****************************************
   localparam int SIRQ_FLAG_PROX  = 3;
   localparam int SIRQ_FLAG_ALS   = 2;
   localparam int SIRQ_FLAG_LOW   = 1;
   localparam int SIRQ_FLAG_HIGH  = 0;
   localparam int SIRQ_DLY_LSB    = 5;
   localparam int SIRQ_FRQ_LSB    = 3;
   localparam int SIRQ_DEAD_LSB   = 0;
   // ****************************************
   // serial engine states
   // ****************************************
   typedef enum logic [2:0] {
      SIRQ_IDLE  = 3'b000,
      SIRQ_ADDR  = 3'b001,
      SIRQ_AACK  = 3'b011,
      SIRQ_WBYTE = 3'b010,
      SIRQ_WACK  = 3'b110,
      SIRQ_RBYTE = 3'b111,
      SIRQ_RACK  = 3'b101
   } sirq_state_t;
endpackage : sirq_pkg

// *** src/sirq_top.sv ***
// interrupt status, modulator timing and i2c register read port of the sensor
//
// Summary of operation
// - status register reports ready and limit events
// - bit3 prox, bit2 light, bit1 low, bit0 high
// - flags stick until host writes one
// - interrupt pad low while any flag set
// - timing register resets to one
// - decode recommended delay, dead, frequency codes
// - standby when no measurement requested
// - standby disables emitter sink, setting kept
// - read returns pointed register byte
// - stop-start or repeated start both accepted
// - pointer increments after every read
`timescale 1ns/1ps
`default_nettype none
module sirq_top (
   input  wire logic       mclk_in,
   input  wire logic       rstn_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   input  wire logic [3:0] event_in,
   input  wire logic       prox_req_in,
   input  wire logic       als_req_in,
   input  wire logic [7:0] ext_rdata_in,
   output logic            int_n_out,
   output logic            standby_out,
   output logic            emitter_diode_en_out,
   output logic [2:0]      mod_delay_out,
   output logic [1:0]      prox_freq_out,
   output logic [2:0]      mod_dead_out,
   output logic            mod_recommended_out,
   output logic [7:0]      reg_ptr_out
);
   import sirq_pkg::*;

   // ****************************************
   // pin synchronisers, three stages each
   // ****************************************
   logic [2:0] scl_s_q;
   logic [2:0] sda_s_q;
   logic       scl_q;
   logic       sda_q;
   always_ff @(posedge mclk_in) begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
      if (!rstn_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         // a change counts only once stages two and three agree
         if (scl_s_q[1] == scl_s_q[2]) scl_q <= scl_s_q[2];
         if (sda_s_q[1] == sda_s_q[2]) sda_q <= sda_s_q[2];
      end
   end

   // ****************************************
   // bus condition decode
   // ****************************************
   wire scl_now   = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_q;
   wire sda_now   = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;
   wire scl_rise  = scl_now & ~scl_q;
   wire scl_fall  = ~scl_now & scl_q;
   wire start_det = scl_q & scl_now & sda_q & ~sda_now;   // also repeated start
   wire stop_det  = scl_q & scl_now & ~sda_q & sda_now;

   // ****************************************
   // serial engine
   // ****************************************
   sirq_state_t st_q;
   logic [7:0]  sh_q;
   logic [2:0]  bit_q;
   logic        rd_q;
   logic        first_q;
   logic        drive_q;
   logic [7:0]  ptr_q;
   logic [7:0]  flags_q;
   logic [7:0]  modtim_q;
   logic        nack_q;
   logic        scl_hi_q;

   // register read mux; reserved flag bits read zero
   wire [7:0] rd_data = (ptr_q == SIRQ_ADDR_FLAGS)  ? flags_q :
                        (ptr_q == SIRQ_ADDR_MODTIM) ? modtim_q :
                        ext_rdata_in;
   wire       byte_done = scl_fall & (bit_q == 3'd7);
   wire       wr_data_strobe = (st_q == SIRQ_WBYTE) & byte_done & ~first_q;
   wire [7:0] wr_byte = sh_q;
   wire       rd_taken = (st_q == SIRQ_RACK) & scl_rise;
   // host acknowledge low means another byte is wanted
   wire       rd_more = rd_taken & ~sda_now;

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         st_q    <= SIRQ_IDLE;
         sh_q    <= 8'h00;
         bit_q   <= 3'd0;
         rd_q    <= 1'b0;
         first_q <= 1'b0;
         drive_q <= 1'b0;
         ptr_q   <= SIRQ_PTR_RST;
         nack_q  <= 1'b0;
         scl_hi_q <= 1'b0;
      end else if (start_det) begin
         // stop then start, or repeated start, both land here
         st_q    <= SIRQ_ADDR;
         bit_q   <= 3'd0;
         drive_q <= 1'b0;
         scl_hi_q <= 1'b0;
      end else if (stop_det) begin
         st_q    <= SIRQ_IDLE;
         drive_q <= 1'b0;
      end else begin
         case (st_q)
            SIRQ_ADDR: begin
               if (scl_rise) begin
                  sh_q     <= {sh_q[6:0], sda_now};
                  scl_hi_q <= 1'b1;
               end
               // the clock fall that closes the start carries no bit, so it must not count
               if (scl_fall & scl_hi_q) begin
                  bit_q <= bit_q + 3'd1;
                  if (bit_q == 3'd7) begin
                     rd_q    <= sh_q[0];
                     nack_q  <= (sh_q[7:1] != SIRQ_SLAVE_ADDR);
                     drive_q <= (sh_q[7:1] == SIRQ_SLAVE_ADDR);
                     st_q    <= (sh_q[7:1] == SIRQ_SLAVE_ADDR) ? SIRQ_AACK : SIRQ_IDLE;
                  end
               end
            end
            SIRQ_AACK: begin
               if (scl_fall) begin
                  bit_q   <= 3'd0;
                  first_q <= 1'b1;
                  if (rd_q) begin
                     sh_q    <= rd_data;
                     drive_q <= ~rd_data[7];
                     st_q    <= SIRQ_RBYTE;
                  end else begin
                     drive_q <= 1'b0;
                     st_q    <= SIRQ_WBYTE;
                  end
               end
            end
            SIRQ_WBYTE: begin
               if (scl_rise) sh_q <= {sh_q[6:0], sda_now};
               if (scl_fall) begin
                  bit_q <= bit_q + 3'd1;
                  if (bit_q == 3'd7) begin
                     if (first_q) ptr_q <= sh_q;
                     else ptr_q <= ptr_q + 8'h01;
                     drive_q <= 1'b1;
                     st_q    <= SIRQ_WACK;
                  end
               end
            end
            SIRQ_WACK: begin
               if (scl_fall) begin
                  drive_q <= 1'b0;
                  first_q <= 1'b0;
                  bit_q   <= 3'd0;
                  st_q    <= SIRQ_WBYTE;
               end
            end
            SIRQ_RBYTE: begin
               if (scl_fall) begin
                  bit_q <= bit_q + 3'd1;
                  if (bit_q == 3'd7) begin
                     drive_q <= 1'b0;                             // release for host ack
                     ptr_q   <= ptr_q + 8'h01;
                     st_q    <= SIRQ_RACK;
                  end else begin
                     sh_q    <= {sh_q[6:0], 1'b0};
                     drive_q <= ~sh_q[6];
                  end
               end
            end
            SIRQ_RACK: begin
               if (rd_taken) st_q <= rd_more ? SIRQ_AACK : SIRQ_IDLE;
            end
            default: st_q <= SIRQ_IDLE;
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   // the pointer moves on only after the byte, so a data write lands at ptr_q itself
   wire       wr_flags  = wr_data_strobe & (ptr_q == SIRQ_ADDR_FLAGS) & ~stop_det & ~start_det;
   wire       wr_modtim = wr_data_strobe & (ptr_q == SIRQ_ADDR_MODTIM) & ~stop_det & ~start_det;
   wire [7:0] ev_bits   = {4'h0, event_in};
   wire [7:0] clr_bits  = wr_flags ? (wr_byte & 8'h0F) : 8'h00;
   // set wins over clear when both land in one cycle
   wire [7:0] flags_d   = (flags_q & ~clr_bits) | ev_bits;

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         flags_q  <= 8'h00;
         modtim_q <= SIRQ_MODTIM_RST;
      end else begin
         flags_q <= flags_d;
         if (wr_modtim) modtim_q <= wr_byte;
      end
   end

   // ****************************************
   // decoded outputs
   // ****************************************
   wire stby = ~(prox_req_in | als_req_in);
   wire rec  = (modtim_q[7:5] == 3'd0) & (modtim_q[2:0] == 3'd1) &
               (modtim_q[4:3] == 2'd0);

   // outputs are registered; the pad is taken from flags_d, so it changes in the same cycle as the flags
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         int_n_out            <= 1'b1;
         standby_out          <= 1'b1;
         emitter_diode_en_out <= 1'b0;
         mod_delay_out        <= SIRQ_MODTIM_RST[7:5];
         prox_freq_out        <= SIRQ_MODTIM_RST[4:3];
         mod_dead_out         <= SIRQ_MODTIM_RST[2:0];
         mod_recommended_out  <= 1'b1;
         sda_out              <= 1'b0;
         sda_oe_out           <= 1'b0;
         reg_ptr_out          <= SIRQ_PTR_RST;
      end else begin
         int_n_out            <= ~(|flags_d[3:0]);
         standby_out          <= stby;
         emitter_diode_en_out <= ~stby;
         mod_delay_out        <= modtim_q[SIRQ_DLY_LSB +: 3];
         prox_freq_out        <= modtim_q[SIRQ_FRQ_LSB +: 2];
         mod_dead_out         <= modtim_q[SIRQ_DEAD_LSB +: 3];
         mod_recommended_out  <= rec;
         sda_out              <= 1'b0;                            // open drain, low only
         sda_oe_out           <= drive_q & ~nack_q;
         reg_ptr_out          <= ptr_q;
      end
   end
endmodule // sirq_top
`default_nettype wire

// *** bench/sirq_sva.sv ***
// checker of the sensor register port, seeing the top ports only
`timescale 1ns/1ps
`default_nettype none
module sirq_sva (
   input wire logic       mclk_in,
   input wire logic       rstn_in,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_oe_out,
   input wire logic [3:0] event_in,
   input wire logic       prox_req_in,
   input wire logic       als_req_in,
   input wire logic       int_n_out,
   input wire logic       standby_out,
   input wire logic       emitter_diode_en_out,
   input wire logic [2:0] mod_delay_out,
   input wire logic [1:0] prox_freq_out,
   input wire logic [2:0] mod_dead_out,
   input wire logic       mod_recommended_out,
   input wire logic [7:0] reg_ptr_out
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   pad_low_a: assert property (event_in != 4'h0 |=> !int_n_out)
      else $error("pad not low after event");
   pad_release_a: assert property ($rose(int_n_out) |-> $past(event_in) == 4'h0)
      else $error("pad released during event");
   wake_up_a: assert property ((prox_req_in || als_req_in) |=> !standby_out)
      else $error("standby despite demand");
   go_standby_a: assert property (!(prox_req_in || als_req_in) |=> standby_out)
      else $error("awake without demand");
   sink_off_a: assert property (!(prox_req_in || als_req_in) |=> !emitter_diode_en_out && standby_out)
      else $error("emitter enable disagrees with standby");
   recommended_a: assert property (mod_recommended_out ==
      (mod_delay_out == 3'h0 && prox_freq_out == 2'h0 && mod_dead_out == 3'h1))
      else $error("recommended flag wrong");
   timing_reset_a: assert property ($rose(rstn_in) |->
      {mod_delay_out, prox_freq_out, mod_dead_out} == 8'h01)
      else $error("timing reset value wrong");
   // eight cycles with both lines high can fall inside a one bit; a write still needs more cycles to reach the fields
   idle_fields_a: assert property ((scl_in && sda_in)[*8] |=>
      $stable({mod_delay_out, prox_freq_out, mod_dead_out}) && !sda_oe_out)
      else $error("fields moved on idle bus");
   idle_ptr_a: assert property ((scl_in && sda_in)[*8] |=> $stable(reg_ptr_out))
      else $error("pointer moved on idle bus");
endmodule // sirq_sva
`default_nettype wire

// *** bench/sirq_host.sv ***
// i2c host model that masters the sensor register port
`timescale 1ns/1ps
`default_nettype none
module sirq_host (
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_oe_out
);
   // ****************************************
   // bus primitives
   // ****************************************
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   // phases of eight cycles, more than twice the minimum the device needs
   task automatic half();
      repeat (8) @(posedge clk_in);
   endtask
   // also serves as repeated start from a low clock
   task automatic start();
      sda_oe_out <= 1'b0;
      half();
      scl_out <= 1'b1;
      half();
      sda_oe_out <= 1'b1;
      half();
      scl_out <= 1'b0;
      half();
   endtask
   task automatic stop();
      sda_oe_out <= 1'b1;
      half();
      scl_out <= 1'b1;
      half();
      sda_oe_out <= 1'b0;
      half();
   endtask
   task automatic bitx(input logic b, output logic r);
      sda_oe_out <= !b;
      half();
      scl_out <= 1'b1;
      half();
      r = sda_in;
      scl_out <= 1'b0;
      half();
   endtask
   // eight bits msb first, then the acknowledge bit
   task automatic xb(input logic [7:0] w, input logic a, output logic [7:0] r, output logic na);
      for (int i = 7; i >= 0; i--) begin
         bitx(w[i], r[i]);
      end
      bitx(a, na);
   endtask
endmodule // sirq_host
`default_nettype wire

// *** bench/sirq_top_tb_top.sv ***
// testbench of the sensor interrupt status and register read port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); end end
module sirq_top_tb_top;
   import sirq_pkg::*;
   logic       mclk_in = 1'b0;
   logic       rstn_in = 1'b0;
   logic [3:0] event_in = 4'h0;
   logic       prox_req_in = 1'b0;
   logic       als_req_in = 1'b0;
   logic       scl;
   logic       host_oe;
   logic       sda_oe_out, int_n_out, standby_out, emitter_diode_en_out, mod_recommended_out;
   logic [2:0] mod_delay_out, mod_dead_out;
   logic [1:0] prox_freq_out;
   logic [7:0] reg_ptr_out;
   logic       sda_out;
   int         fail_count = 0;
   int         checks_done = 0;
   // pull-up: low while the host pulls or the device drives its low level
   wire        sda_line = !(host_oe | (sda_oe_out & !sda_out));
   initial begin
      forever #12.5 mclk_in = ~mclk_in;
   end
   sirq_host host (.clk_in(mclk_in), .sda_in(sda_line), .scl_out(scl), .sda_oe_out(host_oe));
   sirq_top dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe_out(sda_oe_out), .event_in(event_in), .prox_req_in(prox_req_in), .als_req_in(als_req_in),
      .ext_rdata_in(8'h5A), .int_n_out(int_n_out), .standby_out(standby_out),
      .emitter_diode_en_out(emitter_diode_en_out), .mod_delay_out(mod_delay_out),
      .prox_freq_out(prox_freq_out), .mod_dead_out(mod_dead_out),
      .mod_recommended_out(mod_recommended_out), .reg_ptr_out(reg_ptr_out));
   // ****************************************
   // bus tasks
   // ****************************************
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] r;
      logic       na;
      host.start();
      host.xb({SIRQ_SLAVE_ADDR, 1'b0}, 1'b1, r, na);
      host.xb(p, 1'b1, r, na);
      host.xb(d, 1'b1, r, na);
      `CHK(na, 1'b0)
      host.stop();
   endtask
   // pointer write, then stop-start or repeated start, then two reads
   task automatic rd(input logic [7:0] p, input logic rs, input logic [7:0] e0, input logic [7:0] e1);
      logic [7:0] r;
      logic       na;
      host.start();
      host.xb({SIRQ_SLAVE_ADDR, 1'b0}, 1'b1, r, na);
      host.xb(p, 1'b1, r, na);
      if (!rs) host.stop();
      host.start();
      host.xb({SIRQ_SLAVE_ADDR, 1'b1}, 1'b1, r, na);
      `CHK(na, 1'b0)
      host.xb(8'hFF, 1'b0, r, na);
      `CHK(r, e0)
      host.xb(8'hFF, 1'b1, r, na);
      `CHK(r, e1)
      host.stop();
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (10) @(posedge mclk_in);
      #1 `CHK({int_n_out, standby_out, emitter_diode_en_out, mod_delay_out, prox_freq_out, mod_dead_out,
         mod_recommended_out, reg_ptr_out}, {3'b110, 3'h0, 2'h0, 3'h1, 1'b1, 8'h00})
      @(posedge mclk_in) rstn_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      for (int k = 0; k < 4; k++) begin
         {prox_req_in, als_req_in} <= 2'(k);
         repeat (2) @(posedge mclk_in);
         #1 `CHK({standby_out, emitter_diode_en_out}, (k == 0) ? 2'b10 : 2'b01)
      end
      $display("test standby done");
      @(posedge mclk_in) event_in <= 4'hF;
      @(posedge mclk_in) event_in <= 4'h0;
      @(posedge mclk_in);
      #1 `CHK(int_n_out, 1'b0)
      rd(SIRQ_ADDR_FLAGS, 1'b0, 8'h0F, SIRQ_MODTIM_RST);
      wr(SIRQ_ADDR_FLAGS, 8'h00);
      rd(SIRQ_ADDR_FLAGS, 1'b1, 8'h0F, SIRQ_MODTIM_RST);
      wr(SIRQ_ADDR_FLAGS, 8'h05);
      rd(SIRQ_ADDR_FLAGS, 1'b1, 8'h0A, SIRQ_MODTIM_RST);
      #1 `CHK(int_n_out, 1'b0)
      wr(SIRQ_ADDR_FLAGS, 8'h0A);
      rd(SIRQ_ADDR_FLAGS, 1'b0, 8'h00, SIRQ_MODTIM_RST);
      #1 `CHK(int_n_out, 1'b1)
      // a single event must land in its own bit position
      @(posedge mclk_in) event_in <= 4'h2;
      @(posedge mclk_in) event_in <= 4'h0;
      rd(SIRQ_ADDR_FLAGS, 1'b1, 8'h02, SIRQ_MODTIM_RST);
      wr(SIRQ_ADDR_FLAGS, 8'h02);
      #1 `CHK(int_n_out, 1'b1)
      $display("test flags done");
      wr(SIRQ_ADDR_MODTIM, 8'hB5);
      #1 `CHK({mod_delay_out, prox_freq_out, mod_dead_out, mod_recommended_out}, {3'h5, 2'h2, 3'h5, 1'b0})
      rd(SIRQ_ADDR_MODTIM, 1'b1, 8'hB5, 8'h5A);
      #1 `CHK(reg_ptr_out, SIRQ_ADDR_AMBIR + 8'h01)
      wr(SIRQ_ADDR_MODTIM, SIRQ_MODTIM_RST);
      `CHK(mod_recommended_out, 1'b1)
      $display("test timing done");
      tally_and_finish();
   end
   // whole run takes about 0.28 ms of bus traffic
   initial begin
      #2000000;
      fail_count++;
      tally_and_finish();
   end
endmodule // sirq_top_tb_top
bind sirq_top sirq_sva u_sva (.mclk_in(mclk_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_in(sda_in),
   .sda_oe_out(sda_oe_out), .event_in(event_in), .prox_req_in(prox_req_in), .als_req_in(als_req_in),
   .int_n_out(int_n_out), .standby_out(standby_out), .emitter_diode_en_out(emitter_diode_en_out),
   .mod_delay_out(mod_delay_out), .prox_freq_out(prox_freq_out), .mod_dead_out(mod_dead_out),
   .mod_recommended_out(mod_recommended_out), .reg_ptr_out(reg_ptr_out));
`default_nettype wire
